// ### rtl/dwa_datapath.sv
// width conversion and write lane datapath of one transfer engine
`timescale 1ns/10ps
module dwa_datapath
   import dwa_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // channel configuration
   input wire logic i_start,
   input wire logic [1:0] i_source_item_size,
   input wire logic [1:0] i_memory_item_size,
   input wire logic i_source_pointer_increment,
   input wire logic i_memory_pointer_increment,
   input wire logic [ADDR_W-1:0] i_src_base,
   input wire logic [ADDR_W-1:0] i_dst_base,
   input wire logic [COUNT_W-1:0] i_item_count,
   // channel status
   output logic o_busy,
   output logic o_done,
   output logic [COUNT_W-1:0] o_items_left,
   output logic [ADDR_W-1:0] o_src_addr,
   output logic [ADDR_W-1:0] o_dst_addr,
   // bus master
   output logic [ADDR_W-1:0] o_haddr,
   output logic [1:0] o_htrans,
   output logic o_hwrite,
   output logic [2:0] o_hsize,
   output logic [DATA_W-1:0] o_hwdata,
   input wire logic [DATA_W-1:0] i_hrdata,
   input wire logic i_hready,
   // register slave access check
   input wire logic i_reg_hsel,
   input wire logic [1:0] i_reg_htrans,
   input wire logic [2:0] i_reg_hsize,
   input wire logic i_reg_hready,
   output logic o_reg_hreadyout,
   output logic o_reg_hresp,
   output logic o_reg_access_ok,
   // size-blind peripheral word write
   output logic o_pwrite,
   output logic [ADDR_W-1:0] o_paddr,
   output logic [DATA_W-1:0] o_pwdata
);
   dwa_state_t state_r;
   dwa_state_t state_nxt;
   logic [ADDR_W-1:0] src_r;
   logic [ADDR_W-1:0] dst_r;
   logic [COUNT_W-1:0] count_r;
   logic [DATA_W-1:0] item_r;
   logic [DATA_W-1:0] wdata_r;
   logic [1:0] ssize_r;
   logic [1:0] dsize_r;
   logic sinc_r;
   logic dinc_r;
   logic done_r;
   logic err_r;
   logic [DATA_W-1:0] rd_item;
   logic [DATA_W-1:0] rd_shift;
   logic [DATA_W-1:0] lanes;

   function automatic logic [ADDR_W-1:0] step_of(input logic [1:0] sz);
      case (sz)
         SIZE_BYTE: step_of = STEP_BYTE;
         SIZE_HALF: step_of = STEP_HALF;
         default: step_of = STEP_WORD;
      endcase
   endfunction

   function automatic logic [DATA_W-1:0] mask_of(input logic [1:0] sz);
      case (sz)
         SIZE_BYTE: mask_of = MASK_BYTE;
         SIZE_HALF: mask_of = MASK_HALF;
         default: mask_of = MASK_WORD;
      endcase
   endfunction

   function automatic logic [2:0] hsize_of(input logic [1:0] sz);
      case (sz)
         SIZE_BYTE: hsize_of = HSIZE_BYTE;
         SIZE_HALF: hsize_of = HSIZE_HALF;
         default: hsize_of = HSIZE_WORD;
      endcase
   endfunction

   // narrow read data sits on the lane picked by the low address bits,
   // so shift it down and zero everything above the source item
   always_comb begin
      rd_shift = i_hrdata >> {src_r[1:0], 3'h0};
      rd_item = rd_shift & mask_of(ssize_r);
   end

   // destination item is the low bits of the held item, repeated per lane
   always_comb begin
      case (dsize_r)
         SIZE_BYTE: lanes = {4{item_r[7:0]}};
         SIZE_HALF: lanes = {2{item_r[15:0]}};
         default: lanes = item_r;
      endcase
   end

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         DWA_IDLE: begin
            if (i_start && (i_item_count != COUNT_ZERO)) begin
               state_nxt = DWA_RD_ADDR;
            end
         end
         DWA_RD_ADDR: begin
            if (i_hready) begin
               state_nxt = DWA_RD_DATA;
            end
         end
         DWA_RD_DATA: begin
            if (i_hready) begin
               state_nxt = DWA_WR_ADDR;
            end
         end
         DWA_WR_ADDR: begin
            if (i_hready) begin
               state_nxt = DWA_WR_DATA;
            end
         end
         DWA_WR_DATA: begin
            if (i_hready) begin
               // one read and one write make a transaction
               state_nxt = (count_r == COUNT_ONE) ? DWA_IDLE : DWA_RD_ADDR;
            end
         end
         default: state_nxt = DWA_IDLE;
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         state_r <= DWA_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // configuration latched at start so both sizes stay stable per run
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         ssize_r <= SIZE_BYTE;
         dsize_r <= SIZE_BYTE;
         sinc_r <= 1'b0;
         dinc_r <= 1'b0;
      end else if (state_r == DWA_IDLE && i_start) begin
         ssize_r <= i_source_item_size;
         dsize_r <= i_memory_item_size;
         sinc_r <= i_source_pointer_increment;
         dinc_r <= i_memory_pointer_increment;
      end
   end

   // pointers advance independently after each transaction
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         src_r <= '0;
         dst_r <= '0;
      end else if (state_r == DWA_IDLE && i_start) begin
         src_r <= i_src_base;
         dst_r <= i_dst_base;
      end else if (state_r == DWA_WR_DATA && i_hready) begin
         if (sinc_r) begin
            src_r <= src_r + step_of(ssize_r);
         end
         if (dinc_r) begin
            dst_r <= dst_r + step_of(dsize_r);
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         count_r <= COUNT_ZERO;
      end else if (state_r == DWA_IDLE && i_start) begin
         count_r <= i_item_count;
      end else if (state_r == DWA_WR_DATA && i_hready) begin
         count_r <= count_r - COUNT_ONE;
      end
   end

   // read item held until the write; truncation needs no
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         item_r <= '0;
      end else if (state_r == DWA_RD_DATA && i_hready) begin
         item_r <= rd_item;
      end
   end

   // write data registered one cycle ahead of its data phase
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         wdata_r <= '0;
      end else if (state_r == DWA_WR_ADDR && i_hready) begin
         wdata_r <= lanes;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         done_r <= 1'b0;
      end else begin
         done_r <= (state_r == DWA_WR_DATA) && i_hready
            && (count_r == COUNT_ONE);
      end
   end

   // bus address phase outputs
   always_comb begin
      o_htrans = TRANS_IDLE;
      o_hwrite = 1'b0;
      o_haddr = src_r;
      o_hsize = hsize_of(ssize_r);
      if (state_r == DWA_RD_ADDR) begin
         o_htrans = TRANS_NONSEQ;
      end else if (state_r == DWA_WR_ADDR) begin
         o_htrans = TRANS_NONSEQ;
         o_hwrite = 1'b1;
         o_haddr = dst_r;
         o_hsize = hsize_of(dsize_r);
      end
   end

   assign o_hwdata = wdata_r;
   assign o_busy = (state_r != DWA_IDLE);
   assign o_done = done_r;
   assign o_items_left = count_r;
   assign o_src_addr = src_r;
   assign o_dst_addr = dst_r;

   // register port: narrow access answered with a two-cycle error
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         err_r <= 1'b0;
         o_reg_hresp <= RESP_OKAY;
         o_reg_hreadyout <= 1'b1;
         o_reg_access_ok <= 1'b0;
      end else begin
         o_reg_access_ok <= 1'b0;
         if (err_r) begin
            err_r <= 1'b0;
            o_reg_hreadyout <= 1'b1;
         end else if (i_reg_hsel && i_reg_hready
               && i_reg_htrans[1]) begin
            if (i_reg_hsize != HSIZE_WORD) begin
               err_r <= 1'b1;
               o_reg_hresp <= RESP_ERROR;
               o_reg_hreadyout <= 1'b0;
            end else begin
               o_reg_hresp <= RESP_OKAY;
               o_reg_access_ok <= 1'b1;
            end
         end else begin
            o_reg_hresp <= RESP_OKAY;
         end
      end
   end

   dwa_size_blind_bridge u_bridge (
      .i_sys_clk(i_sys_clk),
      .i_sys_rst(i_sys_rst),
      .i_htrans(o_htrans),
      .i_hwrite(o_hwrite),
      .i_haddr(o_haddr),
      .i_hready(i_hready),
      .i_hwdata(o_hwdata),
      .o_pwrite(o_pwrite),
      .o_paddr(o_paddr),
      .o_pwdata(o_pwdata)
   );
endmodule

// ### rtl/dwa_pkg.sv
// package: sizes, encodings and widths for the width alignment datapath
package dwa_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int COUNT_W = 16;
   // item size field encoding, equal to the low bits of the bus size code
   localparam logic [1:0] SIZE_BYTE = 2'h0;
   localparam logic [1:0] SIZE_HALF = 2'h1;
   localparam logic [1:0] SIZE_WORD = 2'h2;
   // bus transfer codes
   localparam logic [1:0] TRANS_IDLE = 2'h0;
   localparam logic [1:0] TRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_BYTE = 3'h0;
   localparam logic [2:0] HSIZE_HALF = 3'h1;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic RESP_OKAY = 1'h0;
   localparam logic RESP_ERROR = 1'h1;
   // pointer steps per item size
   localparam logic [ADDR_W-1:0] STEP_BYTE = 32'h0000_0001;
   localparam logic [ADDR_W-1:0] STEP_HALF = 32'h0000_0002;
   localparam logic [ADDR_W-1:0] STEP_WORD = 32'h0000_0004;
   // item masks for zero extension
   localparam logic [DATA_W-1:0] MASK_BYTE = 32'h0000_00FF;
   localparam logic [DATA_W-1:0] MASK_HALF = 32'h0000_FFFF;
   localparam logic [DATA_W-1:0] MASK_WORD = 32'hFFFF_FFFF;
   localparam logic [ADDR_W-1:0] WORD_ALIGN = 32'hFFFF_FFFC;
   localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
   localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;

   typedef enum logic [2:0] {
      DWA_IDLE,
      DWA_RD_ADDR,
      DWA_RD_DATA,
      DWA_WR_ADDR,
      DWA_WR_DATA
   } dwa_state_t;
endpackage

// ### rtl/dwa_size_blind_bridge.sv
// bridge stage that turns narrow bus writes into aligned word writes
`timescale 1ns/10ps
module dwa_size_blind_bridge
   import dwa_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // bus side write observed from the master
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [ADDR_W-1:0] i_haddr,
   input wire logic i_hready,
   input wire logic [DATA_W-1:0] i_hwdata,
   // peripheral side word write
   output logic o_pwrite,
   output logic [ADDR_W-1:0] o_paddr,
   output logic [DATA_W-1:0] o_pwdata
);
   logic pend_r;
   logic [ADDR_W-1:0] addr_r;

   // address phase captured with the size code discarded
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         pend_r <= 1'b0;
         addr_r <= '0;
      end else if (i_hready) begin
         pend_r <= (i_htrans == TRANS_NONSEQ) && i_hwrite;
         addr_r <= i_haddr & WORD_ALIGN;
      end
   end

   // data phase: word write at the aligned address with replicated lanes
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_pwrite <= 1'b0;
         o_paddr <= '0;
         o_pwdata <= '0;
      end else begin
         o_pwrite <= pend_r && i_hready;
         if (pend_r && i_hready) begin
            o_paddr <= addr_r;
            o_pwdata <= i_hwdata;
         end
      end
   end
endmodule

// ### tb/dwa_ahb_mem.sv
// bus slave memory model, optionally one wait state per data phase
`timescale 1ns/10ps
module dwa_ahb_mem
   import dwa_pkg::*;
(
   // control and bus
   input wire logic i_sys_clk,
   input wire logic i_slow,
   input wire logic [ADDR_W-1:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [DATA_W-1:0] i_hwdata,
   output logic [DATA_W-1:0] o_hrdata,
   output logic o_hready
);
   logic [7:0] mem [0:63];
   logic [ADDR_W-1:0] a_r;
   logic [2:0] s_r;
   logic w_r, ph_r = 0, wt_r = 0;
   logic [DATA_W-1:0] last_r = 0;
   assign o_hready = !(ph_r && i_slow && !wt_r);
   // released data lines toggle so a stale value is never read
   assign o_hrdata = (ph_r && !w_r && o_hready) ?
      {mem[{a_r[5:2], 2'h3}], mem[{a_r[5:2], 2'h2}],
       mem[{a_r[5:2], 2'h1}], mem[{a_r[5:2], 2'h0}]} : ~last_r;
   always @(posedge i_sys_clk) begin
      last_r <= o_hrdata;
      wt_r <= ph_r && !o_hready;
      if (ph_r && o_hready) begin
         ph_r <= 0;
         for (int i = 0; i < 4; i++)
            if (w_r && (s_r == HSIZE_WORD || i == a_r[1:0] ||
                (s_r == HSIZE_HALF && i[1] == a_r[1])))
               mem[{a_r[5:2], 2'(i)}] <= i_hwdata[8*i +: 8];
      end
      if (o_hready && i_htrans[1]) begin
         a_r <= i_haddr;
         s_r <= i_hsize;
         w_r <= i_hwrite;
         ph_r <= 1;
      end
   end
endmodule

// ### tb/dwa_datapath_asserts.sv
// assertion checker for the width alignment datapath
`timescale 1ns/10ps
module dwa_datapath_asserts
   import dwa_pkg::*;
(
   // clock, reset and inputs
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic i_hready,
   input wire logic i_reg_hsel,
   input wire logic [1:0] i_reg_htrans,
   input wire logic [2:0] i_reg_hsize,
   input wire logic i_reg_hready,
   // outputs watched
   input wire logic o_done,
   input wire logic [COUNT_W-1:0] o_items_left,
   input wire logic [ADDR_W-1:0] o_src_addr,
   input wire logic [ADDR_W-1:0] o_dst_addr,
   input wire logic [ADDR_W-1:0] o_haddr,
   input wire logic [1:0] o_htrans,
   input wire logic o_hwrite,
   input wire logic [2:0] o_hsize,
   input wire logic [DATA_W-1:0] o_hwdata,
   input wire logic o_reg_hreadyout,
   input wire logic o_reg_hresp,
   input wire logic o_reg_access_ok,
   input wire logic o_pwrite,
   input wire logic [ADDR_W-1:0] o_paddr
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   logic rd, wr, rq;
   assign rd = o_htrans == TRANS_NONSEQ && !o_hwrite;
   assign wr = o_htrans == TRANS_NONSEQ && o_hwrite;
   assign rq = i_reg_hsel && i_reg_hready && i_reg_htrans[1];
   a_read_addr: assert property (rd |-> o_haddr == o_src_addr)
      else $error("read address differs from source pointer");
   a_write_addr: assert property (wr |-> o_haddr == o_dst_addr)
      else $error("write address differs from destination pointer");
   a_read_then_write: assert property (rd && i_hready |=>
      o_htrans == TRANS_IDLE ##[1:8] wr)
      else $error("read not followed by one write");
   a_byte_lanes: assert property (
      wr && o_hsize == HSIZE_BYTE && i_hready
      |=> o_hwdata == {4{o_hwdata[7:0]}})
      else $error("byte write not on all lanes");
   a_half_lanes: assert property (
      wr && o_hsize == HSIZE_HALF && i_hready
      |=> o_hwdata == {2{o_hwdata[15:0]}})
      else $error("halfword write not on both halves");
   a_reg_word_ok: assert property (
      rq && i_reg_hsize == HSIZE_WORD
      |=> o_reg_access_ok && !o_reg_hresp && o_reg_hreadyout)
      else $error("word register access not accepted");
   a_reg_narrow_err: assert property (
      rq && i_reg_hsize < HSIZE_WORD
      |=> o_reg_hresp && !o_reg_hreadyout ##1 o_reg_hresp && o_reg_hreadyout)
      else $error("narrow register access not refused");
   a_bridge_align: assert property (
      o_pwrite |-> o_paddr[1:0] == 2'h0)
      else $error("bridge word write not aligned");
   a_done_count: assert property (
      o_done |-> o_items_left == COUNT_ZERO)
      else $error("done with items left");
endmodule

bind dwa_datapath dwa_datapath_asserts u_chk (.*);

// ### tb/dwa_datapath_tb.sv
// self-checking bench for the width alignment datapath
`timescale 1ns/10ps
module dwa_datapath_tb;
   import dwa_pkg::*;
   logic clk = 0, rst = 1, start = 0, slow = 0, inc = 1, rsel = 0;
   logic [1:0] ssz = 0, dsz = 0, rtr = 0, htrans;
   logic [2:0] rsz = 0, hsize;
   logic [COUNT_W-1:0] cnt = 0, left;
   logic [31:0] haddr, srca, dsta, paddr, hrdata, hwdata, pwdata;
   logic hready, hwrite, done, rok, rresp, rrdy, pwrite, busy;
   logic [7:0] exp [0:63];
   int n_mismatch = 0, checks = 0;
   always #2 clk = ~clk;
   dwa_datapath dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_start(start),
      .i_source_item_size(ssz), .i_memory_item_size(dsz),
      .i_source_pointer_increment(inc), .i_memory_pointer_increment(inc),
      .i_src_base(32'h0000_0000), .i_dst_base(32'h0000_0020),
      .i_item_count(cnt), .o_busy(busy), .o_done(done), .o_items_left(left),
      .o_src_addr(srca), .o_dst_addr(dsta), .o_haddr(haddr),
      .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize),
      .o_hwdata(hwdata), .i_hrdata(hrdata), .i_hready(hready),
      .i_reg_hsel(rsel), .i_reg_htrans(rtr), .i_reg_hsize(rsz),
      .i_reg_hready(1'b1), .o_reg_hreadyout(rrdy), .o_reg_hresp(rresp),
      .o_reg_access_ok(rok), .o_pwrite(pwrite), .o_paddr(paddr),
      .o_pwdata(pwdata));
   dwa_ahb_mem mem (.i_sys_clk(clk), .i_slow(slow), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
      .i_hwdata(hwdata), .o_hrdata(hrdata), .o_hready(hready));
   task automatic cmp(input string nm, input logic [31:0] e, s);
      checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("MISMATCH %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d n_mismatch %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic xfer(input int s, d, n);
      int k, b, t;
      logic [31:0] e;
      @(negedge clk);
      ssz = 2'(s);
      dsz = 2'(d);
      cnt = 16'(n);
      slow = 1'((s + d) % 2);
      for (k = 32; k < 64; k++) begin
         mem.mem[k] = 8'h00;
         exp[k] = 8'h00;
      end
      start = 1;
      @(negedge clk);
      start = 0;
      cmp("busy", 32'h1, 32'(busy));
      t = 0;
      while (done !== 1'b1 && t < 200) begin
         @(negedge clk);
         t++;
      end
      cmp("done", 32'h1, 32'(done));
      cmp("idle", 32'h0, 32'(busy));
      // the bridge word write of the last item stands in the done cycle
      cmp("bridge wr", 32'h1, 32'(pwrite));
      for (k = 0; k < n; k++)
         for (b = 0; b < (1 << d); b++)
            exp[32 + (k << d) + b] = b < (1 << s) ? mem.mem[(k << s) + b] : 0;
      for (k = 32; k < 64; k++)
         cmp("dst byte", 32'(exp[k]), 32'(mem.mem[k]));
      cmp("src ptr", 32'(n << s), srca);
      cmp("dst ptr", 32'(32 + (n << d)), dsta);
      cmp("left", 32'h0, 32'(left));
      for (b = 0; b < 4; b++)
         e[8*b +: 8] = exp[32 + ((n - 1) << d) + b % (1 << d)];
      cmp("bridge data", e, pwdata);
      cmp("bridge addr", 32'((32 + ((n - 1) << d)) & ~3), paddr);
   endtask
   task automatic reg_acc(input int sz);
      @(negedge clk);
      rsel = 1;
      rtr = TRANS_NONSEQ;
      rsz = 3'(sz);
      @(negedge clk);
      rsel = 0;
      rtr = TRANS_IDLE;
      cmp("reg ok", 32'(sz == 2), 32'(rok));
      cmp("reg resp", 32'(sz < 2), 32'(rresp));
      cmp("reg ready", 32'(sz == 2), 32'(rrdy));
      if (sz < 2) begin
         @(negedge clk);
         cmp("reg resp 2", 32'h1, 32'(rresp));
         cmp("reg ready 2", 32'h1, 32'(rrdy));
         @(negedge clk);
      end
   endtask
   initial begin
      for (int k = 0; k < 16; k++) mem.mem[k] = 8'(8'hB0 + k);
      repeat (3) @(negedge clk);
      rst = 0;
      for (int s = 0; s < 3; s++)
         for (int d = 0; d < 3; d++) xfer(s, d, 4);
      xfer(1, 0, 1);
      for (int z = 0; z < 3; z++) reg_acc(z);
      complete_run();
   end
   // whole run needs well under 2 us
   initial begin
      #6000;
      n_mismatch++;
      complete_run();
   end
endmodule
